/* File: common/nhb_pkg.sv */
package nhb_pkg;

   // Start nibbles
   localparam logic [3:0] START_RD   = 4'hd;
   localparam logic [3:0] START_WR   = 4'he;

   // Transfer size codes
   localparam logic [3:0] SIZE_1     = 4'h0;
   localparam logic [3:0] SIZE_16    = 4'h4;
   localparam logic [3:0] SIZE_32    = 4'h5;

   // Sync and turnaround nibbles
   localparam logic [3:0] WAIT_NIB   = 4'h5;
   localparam logic [3:0] READY_NIB  = 4'h0;
   localparam logic [3:0] ACK_NIB    = 4'h0;
   localparam logic [3:0] TAR_NIB    = 4'hf;
   localparam logic [3:0] FLOAT_NIB  = 4'hf;

   // Cycle counts, held as last index of each phase
   localparam logic [2:0] ADDR_LAST  = 3'h6;
   localparam logic [2:0] WAIT_LAST  = 3'h1;
   localparam logic [4:0] LAST_1     = 5'h00;
   localparam logic [4:0] LAST_16    = 5'h0f;
   localparam logic [4:0] LAST_32    = 5'h1f;
   localparam logic [3:0] H_RD_LAST  = 4'ha;
   localparam logic [3:0] H_WR_LAST  = 4'hc;
   localparam logic [3:0] H_TMO_LAST = 4'h7;

   // Reset values
   localparam logic [27:0] ADDR_RST  = 28'h0000000;
   localparam logic [7:0]  BYTE_RST  = 8'h00;

   typedef enum logic [3:0] {
      D_IDLE  = 4'h0,
      D_ID    = 4'h1,
      D_ADDR  = 4'h2,
      D_SIZE  = 4'h3,
      D_HTAR  = 4'h4,
      D_WLO   = 4'h5,
      D_WHI   = 4'h6,
      D_TAKE  = 4'h7,
      D_WAIT  = 4'h8,
      D_READY = 4'h9,
      D_DLO   = 4'ha,
      D_DHI   = 4'hb,
      D_ACK   = 4'hc,
      D_DTAR  = 4'hd
   } dev_state_e;

   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_SEND  = 3'h1,
      H_TURN  = 3'h2,
      H_SYNC  = 3'h3,
      H_DLO   = 3'h4,
      H_DHI   = 3'h5,
      H_DTAR  = 3'h6,
      H_ABORT = 3'h7
   } host_state_e;

   function automatic logic size_valid(input logic [3:0] code);
      return (code == SIZE_1) || (code == SIZE_16) || (code == SIZE_32);
   endfunction

   function automatic logic [4:0] size_last(input logic [3:0] code);
      logic [4:0] r;
      r = LAST_1;
      if (code == SIZE_16) begin
         r = LAST_16;
      end else if (code == SIZE_32) begin
         r = LAST_32;
      end
      return r;
   endfunction

endpackage

/* File: common/nhb_if.sv */
`timescale 1ns/1ps
interface nhb_if;
   logic       frame_n;
   logic [3:0] h_nib;
   logic       h_oe;
   logic [3:0] d_nib;
   logic       d_oe;
   logic [3:0] nibble;

   // Pulled-up lines read all ones when nobody drives
   assign nibble = d_oe ? d_nib : (h_oe ? h_nib : nhb_pkg::FLOAT_NIB);

   modport host (
      output frame_n,
      output h_nib,
      output h_oe,
      input  nibble
   );

   modport dev (
      input  frame_n,
      input  nibble,
      output d_nib,
      output d_oe
   );
endinterface

/* File: rtl/nhb_target.sv */
// Function
// - Nibble 1101b with frame low starts read
// - Nibble 1110b with frame low starts write
// - Cycle 2 nibble compared with strapped identity
// - Seven address nibbles, most significant first
// - Size codes 0000b, 0100b, 0101b supported
// - Host sends size 0000b on writes
// - Host drives 1111b turnaround then releases
// - Device takes lines after host turnaround
// - Two wait-sync 0101b cycles per byte
// - Ready-sync 0000b one cycle before data
// - Byte sent low nibble then high nibble
// - Five-cycle group repeats for further bytes
// - Device turnaround 1111b then float
// - Host sends write byte low nibble first
// - Write cycle 15 device acknowledges 0000b
// - Write cycle 16 device turnaround 1111b
// - Write cycle 17 device releases lines
// - Frame low mid-transfer aborts and floats
// - Idle with frame high: lines floating
`timescale 1ns/1ps
module nhb_target (
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST,
   input  wire logic [3:0]  I_ID_STRAP,
   input  wire logic [7:0]  I_RD_DATA,
   output logic      [27:0] O_ADDR,
   output logic             O_RD_REQ,
   output logic             O_WR_STB,
   output logic      [7:0]  O_WR_DATA,
   output logic             O_BUSY,
   nhb_if.dev               bus
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   nhb_pkg::dev_state_e state_ff;
   nhb_pkg::dev_state_e nxt_state;
   logic        is_wr_ff;
   logic        nxt_is_wr;
   logic        hit_ff;
   logic        nxt_hit;
   logic [2:0]  cnt_ff;
   logic [2:0]  nxt_cnt;
   logic [4:0]  left_ff;
   logic [4:0]  nxt_left;
   logic [27:0] addr_ff;
   logic [27:0] nxt_addr;
   logic [7:0]  rdat_ff;
   logic [7:0]  nxt_rdat;
   logic [7:0]  wdat_ff;
   logic [7:0]  nxt_wdat;
   logic        rd_req_ff;
   logic        wr_stb_ff;
   logic        oe_ff;
   logic [3:0]  drv_ff;
   logic [3:0]  nxt_drv;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire       frame_low  = ~bus.frame_n;
   wire [3:0] nib        = bus.nibble;
   wire       start_rd   = (nib == nhb_pkg::START_RD);
   wire       start_wr   = (nib == nhb_pkg::START_WR);
   wire       is_start   = start_rd | start_wr;
   wire       id_match   = (nib == I_ID_STRAP);
   wire       size_ok    = nhb_pkg::size_valid(nib);
   wire       addr_done  = (cnt_ff == nhb_pkg::ADDR_LAST);
   wire       wait_done  = (cnt_ff == nhb_pkg::WAIT_LAST);
   wire       last_byte  = (left_ff == nhb_pkg::LAST_1);
   wire       at_ready   = (state_ff == nhb_pkg::D_READY);
   wire       enter_wait = (nxt_state == nhb_pkg::D_WAIT) && (state_ff != nhb_pkg::D_WAIT);
   wire       wr_byte_in = (state_ff == nhb_pkg::D_WHI) && !frame_low;

   // Device drives only in its own phases
   wire nxt_drives = (nxt_state == nhb_pkg::D_TAKE)  ||
                     (nxt_state == nhb_pkg::D_WAIT)  ||
                     (nxt_state == nhb_pkg::D_READY) ||
                     (nxt_state == nhb_pkg::D_DLO)   ||
                     (nxt_state == nhb_pkg::D_DHI)   ||
                     (nxt_state == nhb_pkg::D_ACK)   ||
                     (nxt_state == nhb_pkg::D_DTAR);

   // Unselected transfers are followed silently to keep in step
   wire nxt_oe = nxt_drives & hit_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      if (frame_low) begin
         // A fresh start restarts; anything else abandons the transfer
         nxt_state = is_start ? nhb_pkg::D_ID : nhb_pkg::D_IDLE;
      end else begin
         unique case (state_ff)
            nhb_pkg::D_IDLE: begin
               nxt_state = nhb_pkg::D_IDLE;
            end
            nhb_pkg::D_ID: begin
               nxt_state = nhb_pkg::D_ADDR;
               nxt_cnt   = 3'h0;
            end
            nhb_pkg::D_ADDR: begin
               if (addr_done) begin
                  nxt_state = nhb_pkg::D_SIZE;
               end else begin
                  nxt_cnt = cnt_ff + 3'h1;
               end
            end
            nhb_pkg::D_SIZE: begin
               nxt_state = is_wr_ff ? nhb_pkg::D_WLO : nhb_pkg::D_HTAR;
            end
            nhb_pkg::D_WLO: begin
               nxt_state = nhb_pkg::D_WHI;
            end
            nhb_pkg::D_WHI: begin
               nxt_state = nhb_pkg::D_HTAR;
            end
            nhb_pkg::D_HTAR: begin
               nxt_state = nhb_pkg::D_TAKE;
            end
            nhb_pkg::D_TAKE: begin
               nxt_state = is_wr_ff ? nhb_pkg::D_ACK : nhb_pkg::D_WAIT;
               nxt_cnt   = 3'h0;
            end
            nhb_pkg::D_WAIT: begin
               if (wait_done) begin
                  nxt_state = nhb_pkg::D_READY;
               end else begin
                  nxt_cnt = cnt_ff + 3'h1;
               end
            end
            nhb_pkg::D_READY: begin
               nxt_state = nhb_pkg::D_DLO;
            end
            nhb_pkg::D_DLO: begin
               nxt_state = nhb_pkg::D_DHI;
            end
            nhb_pkg::D_DHI: begin
               nxt_state = last_byte ? nhb_pkg::D_DTAR : nhb_pkg::D_WAIT;
               nxt_cnt   = 3'h0;
            end
            nhb_pkg::D_ACK: begin
               nxt_state = nhb_pkg::D_DTAR;
            end
            nhb_pkg::D_DTAR: begin
               nxt_state = nhb_pkg::D_IDLE;
            end
            default: begin
               nxt_state = nhb_pkg::D_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer fields
   always_comb begin
      nxt_is_wr = is_wr_ff;
      nxt_hit   = hit_ff;
      nxt_left  = left_ff;
      nxt_addr  = addr_ff;
      nxt_wdat  = wdat_ff;
      if (frame_low) begin
         nxt_is_wr = start_wr;
         nxt_hit   = 1'b0;
      end else begin
         unique case (state_ff)
            nhb_pkg::D_ID: begin
               nxt_hit = id_match;
            end
            nhb_pkg::D_ADDR: begin
               nxt_addr = {addr_ff[23:0], nib};
            end
            nhb_pkg::D_SIZE: begin
               // Unsupported sizes are not answered at all
               nxt_hit  = hit_ff & size_ok;
               nxt_left = is_wr_ff ? nhb_pkg::LAST_1 : nhb_pkg::size_last(nib);
            end
            nhb_pkg::D_WLO: begin
               nxt_wdat = {wdat_ff[7:4], nib};
            end
            nhb_pkg::D_WHI: begin
               nxt_wdat = {nib, wdat_ff[3:0]};
            end
            nhb_pkg::D_DHI: begin
               // Bytes of a burst come from consecutive addresses
               nxt_addr = addr_ff + 28'h0000001;
               nxt_left = last_byte ? left_ff : left_ff - 5'h01;
            end
            default: begin
               nxt_hit = hit_ff;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drive value
   assign nxt_rdat = at_ready ? I_RD_DATA : rdat_ff;

   always_comb begin
      nxt_drv = nhb_pkg::TAR_NIB;
      unique case (nxt_state)
         nhb_pkg::D_WAIT:  nxt_drv = nhb_pkg::WAIT_NIB;
         nhb_pkg::D_READY: nxt_drv = nhb_pkg::READY_NIB;
         nhb_pkg::D_DLO:   nxt_drv = nxt_rdat[3:0];
         nhb_pkg::D_DHI:   nxt_drv = nxt_rdat[7:4];
         nhb_pkg::D_ACK:   nxt_drv = nhb_pkg::ACK_NIB;
         nhb_pkg::D_DTAR:  nxt_drv = nhb_pkg::TAR_NIB;
         default:          nxt_drv = nhb_pkg::TAR_NIB;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state_ff  <= nhb_pkg::D_IDLE;
         is_wr_ff  <= 1'b0;
         hit_ff    <= 1'b0;
         cnt_ff    <= 3'h0;
         left_ff   <= nhb_pkg::LAST_1;
         addr_ff   <= nhb_pkg::ADDR_RST;
         rdat_ff   <= nhb_pkg::BYTE_RST;
         wdat_ff   <= nhb_pkg::BYTE_RST;
         rd_req_ff <= 1'b0;
         wr_stb_ff <= 1'b0;
         oe_ff     <= 1'b0;
         drv_ff    <= nhb_pkg::FLOAT_NIB;
      end else begin
         state_ff  <= nxt_state;
         is_wr_ff  <= nxt_is_wr;
         hit_ff    <= nxt_hit;
         cnt_ff    <= nxt_cnt;
         left_ff   <= nxt_left;
         addr_ff   <= nxt_addr;
         rdat_ff   <= nxt_rdat;
         wdat_ff   <= nxt_wdat;
         rd_req_ff <= enter_wait & hit_ff;
         wr_stb_ff <= wr_byte_in & hit_ff;
         oe_ff     <= nxt_oe;
         drv_ff    <= nxt_drv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Frame low gates the enable at once, not an edge later
   assign bus.d_oe   = oe_ff & bus.frame_n;
   assign bus.d_nib  = drv_ff;
   assign O_ADDR     = addr_ff;
   assign O_RD_REQ   = rd_req_ff;
   assign O_WR_STB   = wr_stb_ff;
   assign O_WR_DATA  = wdat_ff;
   assign O_BUSY     = (state_ff != nhb_pkg::D_IDLE);

endmodule

/* File: rtl/nhb_host.sv */
`timescale 1ns/1ps
module nhb_host (
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_START,
   input  wire logic        I_WRITE,
   input  wire logic        I_ABORT,
   input  wire logic [3:0]  I_DEVICE_SELECT_NIBBLE,
   input  wire logic [27:0] I_ADDR,
   input  wire logic [3:0]  I_SIZE,
   input  wire logic [7:0]  I_WDATA,
   output logic             O_BUSY,
   output logic      [7:0]  O_RDATA,
   output logic             O_RVALID,
   output logic             O_DONE,
   output logic             O_ERR,
   nhb_if.host              bus
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   nhb_pkg::host_state_e state_ff;
   nhb_pkg::host_state_e nxt_state;
   logic [51:0] sh_ff;
   logic [51:0] nxt_sh;
   logic [3:0]  cnt_ff;
   logic [3:0]  nxt_cnt;
   logic [3:0]  tmo_ff;
   logic [3:0]  nxt_tmo;
   logic        is_wr_ff;
   logic [4:0]  left_ff;
   logic [4:0]  nxt_left;
   logic [3:0]  lo_ff;
   logic [7:0]  rdata_ff;
   logic        rvalid_ff;
   logic        done_ff;
   logic        err_ff;
   logic        frame_n_ff;
   logic [3:0]  nib_ff;
   logic        oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire [3:0]  nib      = bus.nibble;
   wire        idle     = (state_ff == nhb_pkg::H_IDLE);
   wire        launch   = idle & I_START;
   wire        abort    = !idle && (state_ff != nhb_pkg::H_ABORT) && I_ABORT;
   wire        timeout  = (state_ff == nhb_pkg::H_SYNC) && (tmo_ff == nhb_pkg::H_TMO_LAST) &&
                          (nib != nhb_pkg::READY_NIB) && (nib != nhb_pkg::WAIT_NIB);
   wire [3:0]  size_tx  = I_WRITE ? nhb_pkg::SIZE_1 : I_SIZE;
   wire [3:0]  start_tx = I_WRITE ? nhb_pkg::START_WR : nhb_pkg::START_RD;
   // Writes send the byte low nibble first, then the turnaround
   wire [51:0] pkt_wr   = {start_tx, I_DEVICE_SELECT_NIBBLE, I_ADDR, size_tx, I_WDATA[3:0], I_WDATA[7:4],
                           nhb_pkg::TAR_NIB};
   wire [51:0] pkt_rd   = {start_tx, I_DEVICE_SELECT_NIBBLE, I_ADDR, size_tx, nhb_pkg::TAR_NIB, 8'h00};
   wire        send_end = (cnt_ff == 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_state = state_ff;
      nxt_sh    = sh_ff;
      nxt_cnt   = cnt_ff;
      nxt_tmo   = tmo_ff;
      nxt_left  = left_ff;
      if (abort) begin
         nxt_state = nhb_pkg::H_ABORT;
      end else begin
         unique case (state_ff)
            nhb_pkg::H_IDLE: begin
               if (I_START) begin
                  nxt_state = nhb_pkg::H_SEND;
                  nxt_sh    = I_WRITE ? pkt_wr : pkt_rd;
                  nxt_cnt   = I_WRITE ? nhb_pkg::H_WR_LAST : nhb_pkg::H_RD_LAST;
                  nxt_left  = I_WRITE ? nhb_pkg::LAST_1 : nhb_pkg::size_last(I_SIZE);
               end
            end
            nhb_pkg::H_SEND: begin
               if (send_end) begin
                  nxt_state = nhb_pkg::H_TURN;
               end else begin
                  nxt_sh  = {sh_ff[47:0], 4'h0};
                  nxt_cnt = cnt_ff - 4'h1;
               end
            end
            nhb_pkg::H_TURN: begin
               nxt_state = nhb_pkg::H_SYNC;
               nxt_tmo   = 4'h0;
            end
            nhb_pkg::H_SYNC: begin
               if (nib == nhb_pkg::READY_NIB) begin
                  nxt_state = is_wr_ff ? nhb_pkg::H_DTAR : nhb_pkg::H_DLO;
               end else if (nib == nhb_pkg::WAIT_NIB) begin
                  nxt_tmo = 4'h0;
               end else if (timeout) begin
                  // Nobody answers: give up rather than hang
                  nxt_state = nhb_pkg::H_IDLE;
               end else begin
                  nxt_tmo = tmo_ff + 4'h1;
               end
            end
            nhb_pkg::H_DLO: begin
               nxt_state = nhb_pkg::H_DHI;
            end
            nhb_pkg::H_DHI: begin
               nxt_state = (left_ff == nhb_pkg::LAST_1) ? nhb_pkg::H_DTAR : nhb_pkg::H_SYNC;
               nxt_left  = (left_ff == nhb_pkg::LAST_1) ? left_ff : left_ff - 5'h01;
               nxt_tmo   = 4'h0;
            end
            nhb_pkg::H_DTAR: begin
               nxt_state = nhb_pkg::H_IDLE;
            end
            nhb_pkg::H_ABORT: begin
               nxt_state = nhb_pkg::H_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state_ff   <= nhb_pkg::H_IDLE;
         sh_ff      <= 52'h0;
         cnt_ff     <= 4'h0;
         tmo_ff     <= 4'h0;
         is_wr_ff   <= 1'b0;
         left_ff    <= nhb_pkg::LAST_1;
         lo_ff      <= 4'h0;
         rdata_ff   <= nhb_pkg::BYTE_RST;
         rvalid_ff  <= 1'b0;
         done_ff    <= 1'b0;
         err_ff     <= 1'b0;
         frame_n_ff <= 1'b1;
         nib_ff     <= nhb_pkg::FLOAT_NIB;
         oe_ff      <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         sh_ff      <= nxt_sh;
         cnt_ff     <= nxt_cnt;
         tmo_ff     <= nxt_tmo;
         is_wr_ff   <= launch ? I_WRITE : is_wr_ff;
         left_ff    <= nxt_left;
         lo_ff      <= (state_ff == nhb_pkg::H_DLO) ? nib : lo_ff;
         rdata_ff   <= (state_ff == nhb_pkg::H_DHI) ? {nib, lo_ff} : rdata_ff;
         rvalid_ff  <= (state_ff == nhb_pkg::H_DHI) & !abort;
         done_ff    <= ((state_ff == nhb_pkg::H_DTAR) & !abort) | timeout | (state_ff == nhb_pkg::H_ABORT);
         err_ff     <= timeout | (state_ff == nhb_pkg::H_ABORT);
         frame_n_ff <= !(launch & !abort) && (nxt_state != nhb_pkg::H_ABORT);
         nib_ff     <= nxt_sh[51:48];
         oe_ff      <= (nxt_state == nhb_pkg::H_SEND);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign bus.frame_n = frame_n_ff;
   assign bus.h_nib   = nib_ff;
   assign bus.h_oe    = oe_ff;
   assign O_BUSY      = !idle;
   assign O_RDATA     = rdata_ff;
   assign O_RVALID    = rvalid_ff;
   assign O_DONE      = done_ff;
   assign O_ERR       = err_ff;

endmodule

/* File: sim/nhb_properties.sv */
`timescale 1ns/1ps
module nhb_properties (
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RST,
   input  wire logic       frame_n,
   input  wire logic       h_oe,
   input  wire logic       d_oe,
   input  wire logic [3:0] nibble
);
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RST);
   ////////////////////////////////////////////////////////////////////////////////
   // Helpers: direction of the last start, cycles since it, length of drive run
   logic       wr_ff;
   logic [7:0] pcnt_ff;
   logic [7:0] run_ff;
   wire  logic       nxt_wr   = frame_n ? wr_ff : (nibble == nhb_pkg::START_WR);
   wire  logic [7:0] nxt_pcnt = !frame_n ? 8'h01 : ((pcnt_ff == 8'hff) ? pcnt_ff : pcnt_ff + 8'h01);
   wire  logic [7:0] nxt_run  = d_oe ? run_ff + 8'h01 : 8'h00;
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         wr_ff   <= 1'b0;
         pcnt_ff <= 8'hff;
         run_ff  <= 8'h00;
      end else begin
         wr_ff   <= nxt_wr;
         pcnt_ff <= nxt_pcnt;
         run_ff  <= nxt_run;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_abort_float;
      // The gate alone keeps the first cycle quiet; the state must stay abandoned after it
      !frame_n |-> !d_oe ##1 !d_oe;
   endproperty
   a_abort_float: assert property (p_abort_float) else $error("device drives with frame low");
   property p_owner;
      d_oe |-> !h_oe;
   endproperty
   a_owner: assert property (p_owner) else $error("both ends drive the lines");
   property p_take_time;
      $rose(d_oe) |-> pcnt_ff == (wr_ff ? 8'd13 : 8'd11);
   endproperty
   a_take_time: assert property (p_take_time) else $error("takeover in wrong cycle");
   property p_rd_lead;
      $rose(d_oe) && !wr_ff |-> nibble == nhb_pkg::TAR_NIB ##1 (d_oe && nibble == nhb_pkg::WAIT_NIB) [*2]
         ##1 (d_oe && nibble == nhb_pkg::READY_NIB);
   endproperty
   a_rd_lead: assert property (p_rd_lead) else $error("bad read lead-in");
   property p_wr_tail;
      $rose(d_oe) && wr_ff |-> nibble == nhb_pkg::TAR_NIB ##1 (d_oe && nibble == nhb_pkg::ACK_NIB)
         ##1 (d_oe && nibble == nhb_pkg::TAR_NIB) ##1 !d_oe;
   endproperty
   a_wr_tail: assert property (p_wr_tail) else $error("bad write tail");
   property p_wait;
      d_oe && !wr_ff && run_ff % 8'd5 == 8'd2 |-> nibble == nhb_pkg::WAIT_NIB && $past(nibble) == nhb_pkg::WAIT_NIB;
   endproperty
   a_wait: assert property (p_wait) else $error("wait-sync missing");
   property p_ready;
      d_oe && !wr_ff && run_ff % 8'd5 == 8'd3 |-> nibble == nhb_pkg::READY_NIB;
   endproperty
   a_ready: assert property (p_ready) else $error("ready-sync missing");
   property p_run_len;
      $fell(d_oe) && frame_n |-> (wr_ff ? run_ff == 8'd3 : (run_ff == 8'd7 || run_ff == 8'd82 || run_ff == 8'd162));
   endproperty
   a_run_len: assert property (p_run_len) else $error("drive length wrong");
   property p_window;
      d_oe |-> pcnt_ff >= 8'd11 && pcnt_ff <= 8'd173;
   endproperty
   a_window: assert property (p_window) else $error("device drives outside transfer");
   c_burst: cover property ($fell(d_oe) && run_ff == 8'd162);
   c_write: cover property ($fell(d_oe) && wr_ff);
   c_abort: cover property (!frame_n && !h_oe);
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic        w;
      logic [3:0]  id;
      logic [27:0] a;
      logic [3:0]  sz;
      logic [7:0]  wd;
   } row_s;
   localparam logic [3:0] STRAP = 4'h3;
   logic        clk;
   logic        rst;
   logic        start;
   logic        write;
   logic        abort;
   logic [3:0]  device_select_nibble;
   logic [27:0] addr;
   logic [3:0]  size;
   logic [7:0]  wdata;
   logic [7:0]  rd_data;
   logic        rd_req;
   logic        h_busy;
   logic [27:0] t_addr;
   logic        wr_stb;
   logic [7:0]  wr_data;
   logic        t_busy;
   logic [7:0]  rdata;
   logic        rvalid;
   logic        done;
   logic        err;
   logic        done_seen;
   logic        err_seen;
   logic [27:0] wa;
   logic [7:0]  wd;
   logic [3:0]  nq[$];
   logic [7:0]  rq[$];
   int          n_wr;
   int          n_rq;
   int          n_errors;
   int          tests_run;
   int          cyc;
   row_s        rows [6] = '{
      '{1'b0, STRAP, 28'h0000010, nhb_pkg::SIZE_1, 8'h00},
      '{1'b0, STRAP, 28'hfffffff, nhb_pkg::SIZE_1, 8'h00},
      '{1'b0, STRAP, 28'h1234560, nhb_pkg::SIZE_16, 8'h00},
      '{1'b0, STRAP, 28'h89abcf0, nhb_pkg::SIZE_32, 8'h00},
      '{1'b1, STRAP, 28'h7654321, nhb_pkg::SIZE_1, 8'ha5},
      '{1'b1, STRAP, 28'h0000000, nhb_pkg::SIZE_1, 8'h5a}};
   nhb_if bus_if ();
   nhb_target i_nhb_target (.I_CORE_CLK(clk), .I_RST(rst), .I_ID_STRAP(STRAP), .I_RD_DATA(rd_data),
      .O_ADDR(t_addr), .O_RD_REQ(rd_req), .O_WR_STB(wr_stb), .O_WR_DATA(wr_data), .O_BUSY(t_busy), .bus(bus_if));
   nhb_host i_nhb_host (.I_CORE_CLK(clk), .I_RST(rst), .I_START(start), .I_WRITE(write), .I_ABORT(abort),
      .I_DEVICE_SELECT_NIBBLE(device_select_nibble), .I_ADDR(addr), .I_SIZE(size), .I_WDATA(wdata), .O_BUSY(h_busy), .O_RDATA(rdata),
      .O_RVALID(rvalid), .O_DONE(done), .O_ERR(err), .bus(bus_if));
   nhb_properties i_chk (.I_CORE_CLK(clk), .I_RST(rst), .frame_n(bus_if.frame_n), .h_oe(bus_if.h_oe),
      .d_oe(bus_if.d_oe), .nibble(bus_if.nibble));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] data_of(input logic [27:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Flash side answers from the address it is asked for
   always @(posedge clk) rd_data <= data_of(t_addr);
   always @(posedge clk) begin
      cyc++;
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (rd_req === 1'b1) n_rq++;
      if (bus_if.d_oe === 1'b1) nq.push_back(bus_if.nibble);
      if (wr_stb === 1'b1) begin
         n_wr++;
         wa = t_addr;
         wd = wr_data;
      end
      if (done === 1'b1) begin
         done_seen = 1'b1;
         err_seen = err;
      end
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask
   task automatic xfer(input row_s r, input int ab);
      int k;
      rq.delete();
      nq.delete();
      n_wr = 0;
      n_rq = 0;
      done_seen = 1'b0;
      start <= 1'b1;
      write <= r.w;
      device_select_nibble <= r.id;
      addr <= r.a;
      size <= r.sz;
      wdata <= r.wd;
      @(posedge clk);
      start <= 1'b0;
      if (ab > 0) begin
         repeat (ab) @(posedge clk);
         abort <= 1'b1;
         @(posedge clk);
         abort <= 1'b0;
      end
      k = 0;
      while (!done_seen && k < 400) begin
         @(posedge clk);
         k++;
      end
      chk_bit(done_seen, 1'b1);
      // Spacer so the next start lands after the float cycle
      repeat (2) @(posedge clk);
   endtask
   task automatic check_row(input row_s r, input logic exp_err);
      int n;
      n = (r.sz == nhb_pkg::SIZE_16) ? 16 : ((r.sz == nhb_pkg::SIZE_32) ? 32 : 1);
      chk_bit(err_seen, exp_err);
      chk_bit(h_busy, 1'b0);
      if (exp_err) begin
         chk_val(nq.size(), 0);
         chk_val(n_wr, 0);
         chk_val(n_rq, 0);
      end else if (r.w) begin
         chk_val(n_wr, 1);
         chk_val(wa, r.a);
         chk_val(wd, r.wd);
         chk_val(nq.size(), 3);
         chk_val(nq[1], nhb_pkg::ACK_NIB);
      end else begin
         chk_val(rq.size(), n);
         chk_val(n_rq, n);
         chk_val(nq.size(), 5 * n + 2);
         for (int i = 0; i < n; i++) begin
            chk_val(rq[i], data_of(r.a + 28'(i)));
            chk_val(nq[4 + 5 * i], data_of(r.a + 28'(i)) & 8'h0f);
            chk_val(nq[5 + 5 * i], data_of(r.a + 28'(i)) >> 4);
         end
      end
   endtask
   task automatic summarize();
      $display("errors %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      row_s r;
      rst = 1'b1;
      start = 1'b0;
      write = 1'b0;
      abort = 1'b0;
      device_select_nibble = 4'h0;
      addr = 28'h0;
      size = 4'h0;
      wdata = 8'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_val(bus_if.nibble, nhb_pkg::FLOAT_NIB);
      chk_bit(t_busy, 1'b0);
      foreach (rows[i]) begin
         xfer(rows[i], 0);
         check_row(rows[i], 1'b0);
      end
      r = rows[4];
      r.id = STRAP ^ 4'h1;
      xfer(r, 0);
      check_row(r, 1'b1);
      r = rows[0];
      r.id = STRAP ^ 4'h8;
      xfer(r, 0);
      check_row(r, 1'b1);
      r.id = STRAP;
      r.sz = 4'h1;
      xfer(r, 0);
      check_row(r, 1'b1);
      xfer(rows[2], 30);
      chk_bit(err_seen, 1'b1);
      chk_bit(rq.size() < 16, 1'b1);
      chk_val(bus_if.nibble, nhb_pkg::FLOAT_NIB);
      xfer(rows[0], 0);
      check_row(rows[0], 1'b0);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_val(bus_if.nibble, nhb_pkg::FLOAT_NIB);
      chk_bit(t_busy, 1'b0);
      chk_val(t_addr, nhb_pkg::ADDR_RST);
      chk_bit(h_busy, 1'b0);
      xfer(rows[1], 0);
      check_row(rows[1], 1'b0);
      summarize();
   end
endmodule
